// ---- hdl/odc_defs.vh ----
// Register offsets, field positions, reset values and codes for the output divider/delay block
`ifndef ODC_DEFS_VH
`define ODC_DEFS_VH
`define ODC_ADDR_OUT3_DELAY 8'h2c
`define ODC_ADDR_OUT3_DRV 8'h2d
`define ODC_ADDR_OUT3_MODE 8'h2f
`define ODC_ADDR_OUT4_DIV_HI 8'h30
`define ODC_ADDR_OUT4_DIV_MID 8'h31
`define ODC_ADDR_OUT4_DIV_LO 8'h32
`define ODC_ADDR_OUT4_PHASE 8'h33
`define ODC_RST_VAL 8'h00
`define ODC_COARSE_MSB 5
`define ODC_FINE_LSB 6
`define ODC_EXT_FINE_BIT 4
`define ODC_FUSE_LSB 6
`define ODC_FINE_STEP_PS 30
`define ODC_FINE_MAX_STEPS 3'h4
`define ODC_SUP_1V8 2'h0
`define ODC_SUP_2V5 2'h1
`define ODC_SUP_3V3 2'h2
`define ODC_DRV_LVDS 3'h0
`define ODC_DRV_PECL 3'h1
`define ODC_DRV_CML 3'h2
`define ODC_DRV_HCSL 3'h3
`define ODC_DRV_BLVDS 3'h4
`define ODC_DRV_PECL2 3'h5
`define ODC_MODE_DIFF_EXT 4'h0
`define ODC_MODE_DIFF_PU 4'h2
`define ODC_MODE_DIFF_PD 4'h1
`define ODC_MODE_SE_P 4'h4
`define ODC_MODE_SE_N 4'h8
`define ODC_MODE_SE_PN 4'hc
`endif

// ---- hdl/odc_output_channel.v ----
// Output channel configuration registers, divider and delay for outputs three and four
//
// Behaviour
// (R1) Divider ratio is 20 bits: high nibble, middle byte, low byte.
// (R2) Coarse delay is six-bit code times whole VCO periods, 0 to 63.
// (R3) Fine delay is delay bits 7:6, zero to three 30 ps steps.
// (R4) Extended fine bit makes fine delay three bits, zero to four steps.
// (R5) Supply code: 00 is 1.8 V, 01 is 2.5 V, 10 is 3.3 V.
// (R6) Driver code: LVDS, PECL, CML, HCSL, boosted LVDS, PECL without current.
// (R7) Fuse pattern 01 or 10 means written, 00 or 11 not written.
// (R8) Four mode bits pick termination or single-ended drive per pin.
// (R9) Phase select routes true or complement phase onto each driven pin in single-ended modes only.
// (R10) Output clock is VCO divided by divider (0 or 1 divides by two), delayed by the coarse delay code.
`include "odc_defs.vh"
`default_nettype none
module odc_output_channel #(
   parameter ADDR_W = 8
) (
   input wire clock,
   input wire rst_b,
   input wire reg_wr,
   input wire reg_rd,
   input wire [ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata_r,
   output reg clk_out_p_r,
   output reg clk_out_n_r,
   output reg pull_up_r,
   output reg pull_down_r,
   output reg [1:0] output_supply_code_r,
   output reg [2:0] driver_standard_code_r,
   output reg [2:0] fine_steps_r,
   output reg fuse_written_r
);
   // ----------------------------------------
   // Register file
   // ----------------------------------------
   reg [7:0] delay_r;
   reg [7:0] drv_r;
   reg [7:0] mode_r;
   reg [7:0] div_hi_r;
   reg [7:0] div_mid_r;
   reg [7:0] div_lo_r;
   reg [7:0] phase_r;
   reg [7:0] reg_rdata_nxt;
   // Read mux sees stored values, so a write in the same cycle reads old data
   always @* begin
      reg_rdata_nxt = reg_rdata_r;
      if (reg_rd) begin
         if (reg_addr == `ODC_ADDR_OUT3_DELAY) reg_rdata_nxt = delay_r;
         else if (reg_addr == `ODC_ADDR_OUT3_DRV) reg_rdata_nxt = drv_r;
         else if (reg_addr == `ODC_ADDR_OUT3_MODE) reg_rdata_nxt = mode_r;
         else if (reg_addr == `ODC_ADDR_OUT4_DIV_HI) reg_rdata_nxt = div_hi_r;
         else if (reg_addr == `ODC_ADDR_OUT4_DIV_MID) reg_rdata_nxt = div_mid_r;
         else if (reg_addr == `ODC_ADDR_OUT4_DIV_LO) reg_rdata_nxt = div_lo_r;
         else if (reg_addr == `ODC_ADDR_OUT4_PHASE) reg_rdata_nxt = phase_r;
         else reg_rdata_nxt = 8'h00;
      end
   end
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         delay_r <= `ODC_RST_VAL;
         drv_r <= `ODC_RST_VAL;
         mode_r <= `ODC_RST_VAL;
         div_hi_r <= `ODC_RST_VAL;
         div_mid_r <= `ODC_RST_VAL;
         div_lo_r <= `ODC_RST_VAL;
         phase_r <= `ODC_RST_VAL;
         reg_rdata_r <= 8'h00;
      end else begin
         if (reg_wr) begin
            if (reg_addr == `ODC_ADDR_OUT3_DELAY) delay_r <= reg_wdata;
            else if (reg_addr == `ODC_ADDR_OUT3_DRV) drv_r <= reg_wdata;
            else if (reg_addr == `ODC_ADDR_OUT3_MODE) mode_r <= reg_wdata;
            else if (reg_addr == `ODC_ADDR_OUT4_DIV_HI) div_hi_r <= {4'h0, reg_wdata[3:0]};
            else if (reg_addr == `ODC_ADDR_OUT4_DIV_MID) div_mid_r <= reg_wdata;
            else if (reg_addr == `ODC_ADDR_OUT4_DIV_LO) div_lo_r <= reg_wdata;
            else if (reg_addr == `ODC_ADDR_OUT4_PHASE) phase_r <= reg_wdata;
         end
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // ----------------------------------------
   // Decode of configuration fields
   // ----------------------------------------
   wire [19:0] output_divider_value = {div_hi_r[3:0], div_mid_r, div_lo_r}; // [R1]
   wire [5:0] output_delay_code = delay_r[`ODC_COARSE_MSB:0]; // [R2]
   wire [3:0] mode_bits = mode_r[3:0];
   wire [1:0] phase_sel = phase_r[7:6];
   wire [2:0] fine_code = {mode_r[`ODC_EXT_FINE_BIT], delay_r[`ODC_FINE_LSB+1:`ODC_FINE_LSB]};
   reg [2:0] fine_nxt;
   reg se_p;
   reg se_n;
   always @* begin
      // Extended bit tops a three-bit code; undefined codes above four hold at four
      if (fine_code > `ODC_FINE_MAX_STEPS) begin // [R4]
         fine_nxt = `ODC_FINE_MAX_STEPS;
      end else begin
         fine_nxt = fine_code; // [R3]
      end
      se_p = 1'b0;
      se_n = 1'b0;
      case (mode_bits) // [R8]
         `ODC_MODE_SE_P: se_p = 1'b1;
         `ODC_MODE_SE_N: se_n = 1'b1;
         `ODC_MODE_SE_PN: begin
            se_p = 1'b1;
            se_n = 1'b1;
         end
         default: begin
            se_p = 1'b0;
            se_n = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // Divider and coarse delay on the VCO clock (clock stands in for VCO)
   // ----------------------------------------
   reg [19:0] div_cnt_r;
   reg [5:0] dly_cnt_r;
   reg div_clk_r;
   reg true_clock_phase;
   // Zero or one divider toggles every cycle, giving half the VCO rate, the same as a divider of two
   wire div_bypass = (output_divider_value < 20'h2);
   // Odd ratios keep the exact period; the high phase is one cycle longer
   wire [19:0] div_last = output_divider_value - 20'h1;
   wire [19:0] div_high_len = output_divider_value - {1'b0, output_divider_value[19:1]};
   wire div_wrap = (div_cnt_r >= div_last);
   wire [19:0] div_cnt_nxt = div_wrap ? 20'h0 : div_cnt_r + 20'h1;
   // A new delay code replays older history, so the pin may glitch once
   reg [63:0] dly_line_r;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_r <= 20'h0;
         div_clk_r <= 1'b0;
         dly_line_r <= 64'h0;
         true_clock_phase <= 1'b0;
         dly_cnt_r <= 6'h0;
      end else begin
         if (div_bypass) begin // [R10]
            div_cnt_r <= 20'h0;
            div_clk_r <= ~div_clk_r;
         end else begin
            div_cnt_r <= div_cnt_nxt; // [R10]
            div_clk_r <= (div_cnt_nxt < div_high_len);
         end
         dly_cnt_r <= output_delay_code;
         dly_line_r <= {dly_line_r[62:0], div_clk_r};
         // Tap zero is the undelayed divider output
         true_clock_phase <= (dly_cnt_r == 6'h0) ? div_clk_r : dly_line_r[dly_cnt_r - 6'h1]; // [R2]
      end
   end
   wire complement_clock_phase = ~true_clock_phase;

   // ----------------------------------------
   // Pin routing and clock pin registers
   // ----------------------------------------
   // Phase codes; code three swaps the pins
   localparam PH_STRAIGHT = 2'h0;
   localparam PH_BOTH_TRUE = 2'h1;
   localparam PH_BOTH_COMP = 2'h2;
   reg positive_pin_drive;
   reg negative_pin_drive;
   always @* begin
      case (phase_sel) // [R9]
         PH_STRAIGHT: begin
            positive_pin_drive = true_clock_phase;
            negative_pin_drive = complement_clock_phase;
         end
         PH_BOTH_TRUE: begin
            positive_pin_drive = true_clock_phase;
            negative_pin_drive = true_clock_phase;
         end
         PH_BOTH_COMP: begin
            positive_pin_drive = complement_clock_phase;
            negative_pin_drive = complement_clock_phase;
         end
         default: begin
            positive_pin_drive = complement_clock_phase;
            negative_pin_drive = true_clock_phase;
         end
      endcase
   end
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clk_out_p_r <= 1'b0;
         clk_out_n_r <= 1'b0;
      end else begin
         // Undriven single-ended pin is held low, never left to float
         if (se_p | se_n) begin // [R8]
            clk_out_p_r <= se_p & positive_pin_drive;
            clk_out_n_r <= se_n & negative_pin_drive;
         end else begin
            clk_out_p_r <= true_clock_phase;
            clk_out_n_r <= complement_clock_phase;
         end
      end
   end

   // ----------------------------------------
   // Static configuration outputs
   // ----------------------------------------
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pull_up_r <= 1'b0;
         pull_down_r <= 1'b0;
         output_supply_code_r <= `ODC_SUP_1V8;
         driver_standard_code_r <= `ODC_DRV_LVDS;
         fine_steps_r <= 3'h0;
         fuse_written_r <= 1'b0;
      end else begin
         pull_up_r <= (mode_bits == `ODC_MODE_DIFF_PU); // [R8]
         pull_down_r <= (mode_bits == `ODC_MODE_DIFF_PD);
         output_supply_code_r <= drv_r[4:3]; // [R5]
         driver_standard_code_r <= drv_r[2:0]; // [R6]
         // Fine steps are only reported; sub-cycle delay belongs to the pin driver
         fine_steps_r <= fine_nxt; // [R3]
         fuse_written_r <= ^mode_r[`ODC_FUSE_LSB+1:`ODC_FUSE_LSB]; // [R7]
      end
   end
endmodule // odc_output_channel
`default_nettype wire

// ---- tb/odc_chk_sva.sv ----
// Assertion checker for the output channel configuration block
`default_nettype none
module odc_chk (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata_r,
   input wire logic clk_out_p_r,
   input wire logic pull_up_r,
   input wire logic pull_down_r,
   input wire logic [1:0] output_supply_code_r,
   input wire logic [2:0] driver_standard_code_r,
   input wire logic [2:0] fine_steps_r,
   input wire logic fuse_written_r
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire logic w2d = reg_wr && reg_addr == 8'h2d;
   wire logic w2f = reg_wr && reg_addr == 8'h2f;
   // Decoded outputs trail the stored field by one edge
   a_supply_code: assert property (w2d |-> ##2
      output_supply_code_r == $past(reg_wdata[4:3], 2)) else $error("supply code");
   a_driver_code: assert property (w2d |-> ##2
      driver_standard_code_r == $past(reg_wdata[2:0], 2)) else $error("driver code");
   a_fuse_status: assert property (w2f |-> ##2
      fuse_written_r == ^$past(reg_wdata[7:6], 2)) else $error("fuse status");
   a_pull_up: assert property (w2f |-> ##2
      pull_up_r == ($past(reg_wdata[3:0], 2) == 4'h2)) else $error("pull up");
   a_pull_down: assert property (w2f |-> ##2
      pull_down_r == ($past(reg_wdata[3:0], 2) == 4'h1)) else $error("pull down");
   a_codes_readback: assert property (reg_rd && reg_addr == 8'h2d |=>
      reg_rdata_r[4:0] == {output_supply_code_r, driver_standard_code_r}) else $error("codes");
   a_fuse_readback: assert property (reg_rd && reg_addr == 8'h2f |=>
      fuse_written_r == ^reg_rdata_r[7:6]) else $error("fuse read");
   a_spare_nibble: assert property (reg_rd && reg_addr == 8'h30 |=>
      reg_rdata_r[7:4] == 4'h0) else $error("spare nibble");
   cover property (w2f && reg_wdata[3:0] == 4'hc);
   cover property (fine_steps_r == 3'h4);
   cover property ($rose(clk_out_p_r));
endmodule // odc_chk
bind odc_output_channel odc_chk i_odc_chk (.clock, .rst_b, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata_r, .clk_out_p_r, .pull_up_r, .pull_down_r, .output_supply_code_r,
   .driver_standard_code_r, .fine_steps_r, .fuse_written_r);
`default_nettype wire

// ---- tb/odc_output_channel_tb_top.sv ----
// Self-checking bench for the output channel configuration block
`default_nettype none
module odc_output_channel_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clk_out_p_r, clk_out_n_r;
   logic pull_up_r, pull_down_r, fuse_written_r;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r, v;
   logic [1:0] output_supply_code_r;
   logic [2:0] driver_standard_code_r, fine_steps_r;
   int n_fail = 0, samples_checked = 0, cyc = 0, t0, t1, t2;
   logic [7:0] regs [7] = '{8'h2c, 8'h2d, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33};
   odc_output_channel i_odc_output_channel (.clock, .rst_b, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata_r, .clk_out_p_r, .clk_out_n_r, .pull_up_r, .pull_down_r,
      .output_supply_code_r, .driver_standard_code_r, .fine_steps_r, .fuse_written_r);
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic chk(logic [31:0] seen, logic [31:0] exp, string nm);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock) #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock) #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clock) #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock) #1;
      reg_rd = 1'b0;
      v = reg_rdata_r;
   endtask
   // Waits for a low then a high level, so a pin already high is not taken as a rise
   task automatic rise(output int t);
      int k;
      for (k = 0; k < 600 && clk_out_p_r !== 1'b0; k++)
         @(posedge clock) #1;
      for (k = 0; k < 600 && clk_out_p_r !== 1'b1; k++)
         @(posedge clock) #1;
      t = cyc;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      #1 rst_b = 1'b1;
      foreach (regs[i]) begin
         rd(regs[i]);
         chk(v, 8'h00, "reset value");
         wr(regs[i], 8'hc0 + 8'(i));
         rd(regs[i]);
         chk(v, (8'hc0 + 8'(i)) & (regs[i] == 8'h30 ? 8'h0f : 8'hff), "readback");
      end
      wr(8'h2e, 8'hff);
      rd(8'h2e);
      chk(v, 8'h00, "unmapped");
      $display("registers done");
      for (int i = 0; i < 6; i++) begin
         wr(8'h2d, {3'h0, 2'(i % 3), 3'(i)});
         @(posedge clock) #1;
         chk(output_supply_code_r, i % 3, "supply");
         chk(driver_standard_code_r, i, "driver");
      end
      for (int i = 0; i < 8; i++) begin
         wr(8'h2f, {2'(i), 1'b0, i[2], 2'h0, i % 3 == 1, i % 3 == 2});
         wr(8'h2c, {2'(i), 6'h00});
         @(posedge clock) #1;
         chk(fuse_written_r, ^i[1:0], "fuse");
         chk({pull_up_r, pull_down_r}, {i % 3 == 1, i % 3 == 2}, "pulls");
         chk(fine_steps_r, i > 4 ? 4 : i, "fine");
      end
      $display("codes done");
      wr(8'h30, 8'h00);
      wr(8'h31, 8'h00);
      wr(8'h32, 8'h00);
      for (int i = 0; i < 12; i++) begin
         wr(8'h33, {2'(i), 6'h00});
         wr(8'h2f, i < 4 ? 8'h04 : i < 8 ? 8'h08 : 8'h0c);
         repeat (12) @(posedge clock) #1;
         chk(i < 4 ? clk_out_n_r : i < 8 ? clk_out_p_r : clk_out_p_r ^ clk_out_n_r,
            i > 7 && (i % 4 == 0 || i % 4 == 3), "pins");
      end
      $display("pins done");
      wr(8'h31, 8'h01);
      wr(8'h2f, 8'h00);
      wr(8'h2c, 8'h00);
      repeat (300) @(posedge clock) #1;
      rise(t0);
      wr(8'h2c, 8'h3f);
      rise(t1);
      rise(t2);
      chk(t1 - t0, 63, "coarse delay");
      chk(t2 - t1, 256, "period");
      wr(8'h31, 8'h00);
      wr(8'h32, 8'h05);
      repeat (100) @(posedge clock) #1;
      rise(t0);
      rise(t1);
      chk(t1 - t0, 5, "odd period");
      $display("divider and delay done");
      conclude();
   end
endmodule // odc_output_channel_tb_top
`default_nettype wire
